// ---- include/abrc_pkg.sv ----
package abrc_pkg;
  // Register word indices; byte address is index times four
  localparam int unsigned APB_AW        = 10;
  localparam int unsigned BYTE_SHIFT    = 2;
  localparam logic [7:0]  IDX_CODEC_CLK = 8'h03;
  localparam logic [7:0]  IDX_TX_CTRL   = 8'h04;
  localparam logic [7:0]  IDX_RX_CTRL   = 8'h05;
  localparam logic [7:0]  IDX_BYPASS    = 8'h06;
  localparam logic [7:0]  IDX_HDR_CTRL  = 8'h07;
  localparam logic [7:0]  IDX_ADC_MISC  = 8'h08;

  // Codec clock routing fields
  localparam int unsigned CCK_DIR    = 0;
  localparam int unsigned CCK_SEL_LO = 1;
  localparam int unsigned CCK_SEL_HI = 2;
  // Transmitter fields
  localparam int unsigned TX_FMT    = 1;
  localparam int unsigned TX_RATIO  = 2;
  localparam int unsigned TX_SEL_LO = 3;
  localparam int unsigned TX_SEL_HI = 5;
  // Receiver fields
  localparam int unsigned RX_RECOVERED_MASTER_CLOCK  = 0;
  localparam int unsigned RX_FMT   = 1;
  localparam int unsigned RX_RATIO = 2;
  localparam int unsigned RX_MS    = 3;
  localparam int unsigned RX_RST   = 4;
  // Bypass fields
  localparam int unsigned BY_AUX    = 4;
  localparam int unsigned BY_DSPDAC = 6;
  localparam int unsigned BY_BYPASS = 7;
  // Header fields
  localparam int unsigned HD_MCLK   = 0;
  localparam int unsigned HD_SEL_LO = 3;
  localparam int unsigned HD_SEL_HI = 5;
  // ADC and divider fields
  localparam int unsigned AM_RST      = 0;
  localparam int unsigned AM_FMT      = 1;
  localparam int unsigned AM_DIV_SEL  = 2;
  localparam int unsigned AM_DIV_EN   = 3;
  localparam int unsigned INT_DIV_SEL = 4;
  localparam int unsigned INT_DIV_EN  = 5;

  // Implemented bits per register
  localparam logic [7:0] MASK_CODEC_CLK = 8'h07;
  localparam logic [7:0] MASK_TX_CTRL   = 8'h3E;
  localparam logic [7:0] MASK_RX_CTRL   = 8'h1F;
  localparam logic [7:0] MASK_BYPASS    = 8'hD0;
  localparam logic [7:0] MASK_HDR_CTRL  = 8'h39;
  localparam logic [7:0] MASK_ADC_MISC  = 8'h3F;

  // Reset values
  localparam logic [7:0] RST_CODEC_CLK = 8'h06;
  localparam logic [7:0] RST_TX_CTRL   = 8'h20;
  localparam logic [7:0] RST_RX_CTRL   = 8'h18;
  localparam logic [7:0] RST_BYPASS    = 8'hC0;
  localparam logic [7:0] RST_HDR_CTRL  = 8'h00;
  localparam logic [7:0] RST_ADC_MISC  = 8'h01;

  // Select codes
  localparam logic [1:0] CCK_SEL_DSP = 2'h2;
  localparam logic [1:0] CCK_SEL_TDM = 2'h3;
  localparam logic [2:0] TX_SEL_ADC1 = 3'h4;
  localparam logic [2:0] TX_SEL_ADC2 = 3'h5;
  localparam logic [2:0] TX_SEL_ADC3 = 3'h6;
  localparam logic [2:0] TX_SEL_EXT  = 3'h7;
  localparam logic [2:0] HD_SEL_RAW  = 3'h0;
  localparam logic [2:0] HD_SEL_ADC1 = 3'h1;
  localparam logic [2:0] HD_SEL_ADC2 = 3'h2;
  localparam logic [2:0] HD_SEL_ADC3 = 3'h3;
  localparam logic [2:0] HD_SEL_EXT  = 3'h4;
  localparam logic [2:0] HD_SEL_ADC1B = 3'h5;
  localparam logic [2:0] HD_SEL_ADC2B = 3'h6;
  localparam logic [2:0] HD_SEL_ADC3B = 3'h7;
  // TDM slot positions
  localparam int unsigned SLOT_ADC1 = 0;
  localparam int unsigned SLOT_ADC2 = 1;
  localparam int unsigned SLOT_ADC3 = 2;
  localparam int unsigned SLOT_EXT  = 3;

  // Timing
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned RST_PULSE_US  = 300;
  localparam int unsigned RST_PULSE_CYC = (RST_PULSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Divider phase counter wrap points (1.5: 2 of 3 cycles, 2.0: 1 of 2)
  localparam logic [1:0] DIV15_LAST = 2'h2;
  localparam logic [1:0] DIV20_LAST = 2'h1;
endpackage

// ---- design/abrc_routing_ctrl.sv ----
// The APB register port was left to the implementer.
`timescale 1ns/10ps
// How it works
// - Codec clock mux: 10 DSP, 11 TDM
// - Direction bit 0 drives codec clock bus
// - Transmitter data from TDM slot, codes 100-111
// - Transmitter ratio bit: 0 256Fs, 1 128Fs
// - Transmitter format bit: 0 LJ, 1 I2S
// - Receiver reset bit, low 300us at init
// - Receiver config change pulses reset 300us
// - Receiver role bit passed straight out as rx_master_mode
// - Receiver ratio bit: 0 256Fs, 1 128Fs
// - Receiver format bit: 0 LJ, 1 I2S
// - Recovered clock buffer enabled when 0
// - Bypass buffer enabled when 0
// - DAC data source exclusive, inverse internal
// - Aux input: external ADC or receiver data
// - Header data raw or TDM slot
// - Header master clock drives bus when 1
// - Internal clock divide by 1.5 or 2.0
// - ADC clock divide by 1.5 or 2.0
// - ADC format change pulses ADC reset
// - ADC reset bit, low 300us init/change
// - All registers readable, reset to defaults
module abrc_routing_ctrl #(
  parameter int unsigned RST_PULSE_CYCLES = abrc_pkg::RST_PULSE_CYC
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic [abrc_pkg::APB_AW-1:0] paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        dsp_bclk,
  input  wire logic                        dsp_lrck,
  input  wire logic                        tdm_bclk,
  input  wire logic                        tdm_lrck,
  input  wire logic [3:0]                  tdm_slot_data,
  input  wire logic                        converter_serial_output,
  input  wire logic                        rx_sdout,
  output logic                             codec_bclk_o,
  output logic                             codec_lrck_o,
  output logic                             codec_clk_oe_n,
  output logic                             tx_data_o,
  output logic                             tx_clock_ratio_select,
  output logic                             tx_serial_format_select,
  output logic                             rx_reset_n,
  output logic                             rx_master_mode,
  output logic                             rx_clock_ratio_select,
  output logic                             rx_serial_format_select,
  output logic                             recovered_clock_drive_n,
  output logic                             bypass_buf_en_n,
  output logic                             dsp_dac_ext_en_n,
  output logic                             fpga_dac_buf_en_n,
  output logic                             adc_aux_ext_en_n,
  output logic                             aux_serial_input_o,
  output logic                             aux_oe_n,
  output logic                             hdr_data_o,
  output logic                             dsp_mclk_drive,
  output logic                             adc_serial_format,
  output logic                             adc_reset_n,
  output logic                             int_clk_en,
  output logic                             adc_clk_en
);

  localparam int unsigned     CW         = $clog2(RST_PULSE_CYCLES + 1);
  localparam logic [CW-1:0]   PULSE_LOAD = CW'(RST_PULSE_CYCLES);
  localparam logic [CW-1:0]   CNT_ONE    = CW'(1);
  localparam logic [CW-1:0]   CNT_ZERO   = CW'(0);

  logic [7:0]    cck_r, cck_nxt;
  logic [7:0]    tx_r, tx_nxt;
  logic [7:0]    rx_r, rx_nxt;
  logic [7:0]    by_r, by_nxt;
  logic [7:0]    hd_r, hd_nxt;
  logic [7:0]    am_r, am_nxt;
  logic [31:0]   prdata_r, prdata_nxt;
  logic          pslverr_r, pslverr_nxt;
  logic [7:0]    wix;
  logic [7:0]    wdata8;
  logic [7:0]    rd_mux;
  logic          hit;
  logic          wr_en;
  logic          rx_chg;
  logic          adc_chg;
  logic [CW-1:0] rx_cnt_r, rx_cnt_nxt;
  logic [CW-1:0] am_cnt_r, am_cnt_nxt;
  logic          rx_rst_n_r, rx_rst_n_nxt;
  logic          am_rst_n_r, am_rst_n_nxt;
  logic [1:0]    div_en;
  logic [1:0]    div_sel;
  logic [1:0]    div_pulse;
  logic          bclk_r, bclk_nxt;
  logic          lrck_r, lrck_nxt;
  logic          txd_r, txd_nxt;
  logic          hdr_r, hdr_nxt;
  logic          aux_r, aux_nxt;

  // Address decode: word aligned, six mapped words
  assign wix    = paddr[abrc_pkg::APB_AW-1:abrc_pkg::BYTE_SHIFT];
  assign wdata8 = pwdata[7:0];
  always_comb begin
    hit    = 1'b0;
    rd_mux = 8'h00;
    if (paddr[abrc_pkg::BYTE_SHIFT-1:0] == '0) begin
      case (wix)
        abrc_pkg::IDX_CODEC_CLK: begin
          hit    = 1'b1;
          rd_mux = cck_r;
        end
        abrc_pkg::IDX_TX_CTRL: begin
          hit    = 1'b1;
          rd_mux = tx_r;
        end
        abrc_pkg::IDX_RX_CTRL: begin
          hit    = 1'b1;
          rd_mux = rx_r;
        end
        abrc_pkg::IDX_BYPASS: begin
          hit    = 1'b1;
          rd_mux = by_r;
        end
        abrc_pkg::IDX_HDR_CTRL: begin
          hit    = 1'b1;
          rd_mux = hd_r;
        end
        abrc_pkg::IDX_ADC_MISC: begin
          hit    = 1'b1;
          rd_mux = am_r;
        end
        default: begin
          hit    = 1'b0;
          rd_mux = 8'h00;
        end
      endcase
    end
  end

  // Zero wait state slave; write lands in the access cycle
  assign pready = 1'b1;
  assign wr_en  = psel & penable & pwrite & pstrb[0] & hit;

  // Register file next state; reserved bits are never stored
  always_comb begin
    cck_nxt = cck_r;
    tx_nxt  = tx_r;
    rx_nxt  = rx_r;
    by_nxt  = by_r;
    hd_nxt  = hd_r;
    am_nxt  = am_r;
    if (wr_en) begin
      case (wix)
        abrc_pkg::IDX_CODEC_CLK: cck_nxt = wdata8 & abrc_pkg::MASK_CODEC_CLK;
        abrc_pkg::IDX_TX_CTRL:   tx_nxt  = wdata8 & abrc_pkg::MASK_TX_CTRL;
        abrc_pkg::IDX_RX_CTRL:   rx_nxt  = wdata8 & abrc_pkg::MASK_RX_CTRL;
        abrc_pkg::IDX_BYPASS:    by_nxt  = wdata8 & abrc_pkg::MASK_BYPASS;
        abrc_pkg::IDX_HDR_CTRL:  hd_nxt  = wdata8 & abrc_pkg::MASK_HDR_CTRL;
        abrc_pkg::IDX_ADC_MISC:  am_nxt  = wdata8 & abrc_pkg::MASK_ADC_MISC;
        default:                 cck_nxt = cck_r;
      endcase
    end
  end

  // Read data and error are captured in the setup cycle
  always_comb begin
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    if (psel && !penable) begin
      prdata_nxt  = {24'h00_0000, rd_mux};
      pslverr_nxt = ~hit;
    end
  end

  // Register file and bus response flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cck_r     <= abrc_pkg::RST_CODEC_CLK;
      tx_r      <= abrc_pkg::RST_TX_CTRL;
      rx_r      <= abrc_pkg::RST_RX_CTRL;
      by_r      <= abrc_pkg::RST_BYPASS;
      hd_r      <= abrc_pkg::RST_HDR_CTRL;
      am_r      <= abrc_pkg::RST_ADC_MISC;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      cck_r     <= cck_nxt;
      tx_r      <= tx_nxt;
      rx_r      <= rx_nxt;
      by_r      <= by_nxt;
      hd_r      <= hd_nxt;
      am_r      <= am_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  // Change detectors for the automatic reset pulses
  assign rx_chg  = rx_nxt[abrc_pkg::RX_MS:abrc_pkg::RX_FMT] != rx_r[abrc_pkg::RX_MS:abrc_pkg::RX_FMT];
  assign adc_chg = am_nxt[abrc_pkg::AM_FMT] != am_r[abrc_pkg::AM_FMT];

  // Reset pulse counters; reload on each change, so pulses stretch
  always_comb begin
    rx_cnt_nxt = rx_cnt_r;
    am_cnt_nxt = am_cnt_r;
    if (rx_chg) begin
      rx_cnt_nxt = PULSE_LOAD;
    end else if (rx_cnt_r != CNT_ZERO) begin
      rx_cnt_nxt = rx_cnt_r - CNT_ONE;
    end
    if (adc_chg) begin
      am_cnt_nxt = PULSE_LOAD;
    end else if (am_cnt_r != CNT_ZERO) begin
      am_cnt_nxt = am_cnt_r - CNT_ONE;
    end
    rx_rst_n_nxt = rx_nxt[abrc_pkg::RX_RST] & (rx_cnt_nxt == CNT_ZERO);
    am_rst_n_nxt = am_nxt[abrc_pkg::AM_RST] & (am_cnt_nxt == CNT_ZERO);
  end

  // Counters start loaded so both resets are low after init
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_cnt_r   <= PULSE_LOAD;
      am_cnt_r   <= PULSE_LOAD;
      rx_rst_n_r <= 1'b0;
      am_rst_n_r <= 1'b0;
    end else begin
      rx_cnt_r   <= rx_cnt_nxt;
      am_cnt_r   <= am_cnt_nxt;
      rx_rst_n_r <= rx_rst_n_nxt;
      am_rst_n_r <= am_rst_n_nxt;
    end
  end
  assign rx_reset_n  = rx_rst_n_r;
  assign adc_reset_n = am_rst_n_r;

  // Divider controls: index 0 internal logic, index 1 external ADC
  assign div_en[0]  = am_r[abrc_pkg::INT_DIV_EN];
  assign div_sel[0] = am_r[abrc_pkg::INT_DIV_SEL];
  assign div_en[1]  = am_r[abrc_pkg::AM_DIV_EN];
  assign div_sel[1] = am_r[abrc_pkg::AM_DIV_SEL];

  // Master clock dividers as enable pulses; undivided when disabled
  for (genvar g = 0; g < 2; g++) begin : g_div
    logic [1:0] cnt_r, cnt_nxt;
    logic [1:0] last;
    always_comb begin
      last    = div_sel[g] ? abrc_pkg::DIV20_LAST : abrc_pkg::DIV15_LAST;
      cnt_nxt = (cnt_r >= last) ? 2'h0 : cnt_r + 2'h1;
      if (!div_en[g]) begin
        div_pulse[g] = 1'b1;
      end else if (div_sel[g]) begin
        div_pulse[g] = (cnt_r == 2'h0);
      end else begin
        div_pulse[g] = (cnt_r != abrc_pkg::DIV15_LAST);
      end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        cnt_r <= 2'h0;
      end else begin
        cnt_r <= cnt_nxt;
      end
    end
  end
  assign int_clk_en = div_pulse[0];
  assign adc_clk_en = div_pulse[1];

  // Routing muxes for sub-clocks and serial data
  always_comb begin
    bclk_nxt = 1'b0;
    lrck_nxt = 1'b0;
    txd_nxt  = 1'b0;
    hdr_nxt  = 1'b0;
    unique case (cck_r[abrc_pkg::CCK_SEL_HI:abrc_pkg::CCK_SEL_LO])
      abrc_pkg::CCK_SEL_DSP: begin
        bclk_nxt = dsp_bclk;
        lrck_nxt = dsp_lrck;
      end
      abrc_pkg::CCK_SEL_TDM: begin
        bclk_nxt = tdm_bclk;
        lrck_nxt = tdm_lrck;
      end
      default: begin
        bclk_nxt = 1'b0;
        lrck_nxt = 1'b0;
      end
    endcase
    unique case (tx_r[abrc_pkg::TX_SEL_HI:abrc_pkg::TX_SEL_LO])
      abrc_pkg::TX_SEL_ADC1: txd_nxt = tdm_slot_data[abrc_pkg::SLOT_ADC1];
      abrc_pkg::TX_SEL_ADC2: txd_nxt = tdm_slot_data[abrc_pkg::SLOT_ADC2];
      abrc_pkg::TX_SEL_ADC3: txd_nxt = tdm_slot_data[abrc_pkg::SLOT_ADC3];
      abrc_pkg::TX_SEL_EXT:  txd_nxt = tdm_slot_data[abrc_pkg::SLOT_EXT];
      default:               txd_nxt = 1'b0;
    endcase
    unique case (hd_r[abrc_pkg::HD_SEL_HI:abrc_pkg::HD_SEL_LO])
      abrc_pkg::HD_SEL_RAW:   hdr_nxt = converter_serial_output;
      abrc_pkg::HD_SEL_ADC1:  hdr_nxt = tdm_slot_data[abrc_pkg::SLOT_ADC1];
      abrc_pkg::HD_SEL_ADC2:  hdr_nxt = tdm_slot_data[abrc_pkg::SLOT_ADC2];
      abrc_pkg::HD_SEL_ADC3:  hdr_nxt = tdm_slot_data[abrc_pkg::SLOT_ADC3];
      abrc_pkg::HD_SEL_EXT:   hdr_nxt = tdm_slot_data[abrc_pkg::SLOT_EXT];
      abrc_pkg::HD_SEL_ADC1B: hdr_nxt = tdm_slot_data[abrc_pkg::SLOT_ADC1];
      abrc_pkg::HD_SEL_ADC2B: hdr_nxt = tdm_slot_data[abrc_pkg::SLOT_ADC2];
      abrc_pkg::HD_SEL_ADC3B: hdr_nxt = tdm_slot_data[abrc_pkg::SLOT_ADC3];
    endcase
    aux_nxt = by_r[abrc_pkg::BY_AUX] & rx_sdout;
  end

  // Routed signals leave through flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bclk_r <= 1'b0;
      lrck_r <= 1'b0;
      txd_r  <= 1'b0;
      hdr_r  <= 1'b0;
      aux_r  <= 1'b0;
    end else begin
      bclk_r <= bclk_nxt;
      lrck_r <= lrck_nxt;
      txd_r  <= txd_nxt;
      hdr_r  <= hdr_nxt;
      aux_r  <= aux_nxt;
    end
  end
  assign codec_bclk_o       = bclk_r;
  assign codec_lrck_o       = lrck_r;
  assign tx_data_o          = txd_r;
  assign hdr_data_o         = hdr_r;
  assign aux_serial_input_o = aux_r;

  // Buffer controls and converter mode lines straight from registers
  assign codec_clk_oe_n          = cck_r[abrc_pkg::CCK_DIR];
  assign tx_clock_ratio_select   = tx_r[abrc_pkg::TX_RATIO];
  assign tx_serial_format_select = tx_r[abrc_pkg::TX_FMT];
  assign rx_master_mode          = rx_r[abrc_pkg::RX_MS];
  assign rx_clock_ratio_select   = rx_r[abrc_pkg::RX_RATIO];
  assign rx_serial_format_select = rx_r[abrc_pkg::RX_FMT];
  assign recovered_clock_drive_n = rx_r[abrc_pkg::RX_RECOVERED_MASTER_CLOCK];
  assign bypass_buf_en_n         = by_r[abrc_pkg::BY_BYPASS];
  assign dsp_dac_ext_en_n        = by_r[abrc_pkg::BY_DSPDAC];
  assign fpga_dac_buf_en_n       = ~by_r[abrc_pkg::BY_DSPDAC];
  assign adc_aux_ext_en_n        = by_r[abrc_pkg::BY_AUX];
  assign aux_oe_n                = ~by_r[abrc_pkg::BY_AUX];
  assign dsp_mclk_drive          = hd_r[abrc_pkg::HD_MCLK];
  assign adc_serial_format       = am_r[abrc_pkg::AM_FMT];

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_codec_dsp_route: assert property (
    (cck_r[abrc_pkg::CCK_SEL_HI:abrc_pkg::CCK_SEL_LO] == abrc_pkg::CCK_SEL_DSP)
      |=> (codec_bclk_o == $past(dsp_bclk)) && (codec_lrck_o == $past(dsp_lrck)))
    else $error("codec clocks not from header");
  a_clk_dir_write: assert property (
    (wr_en && wix == abrc_pkg::IDX_CODEC_CLK) |=> codec_clk_oe_n == $past(pwdata[abrc_pkg::CCK_DIR]))
    else $error("clock direction not applied");
  a_tx_ext_route: assert property (
    (tx_r[abrc_pkg::TX_SEL_HI:abrc_pkg::TX_SEL_LO] == abrc_pkg::TX_SEL_EXT)
      |=> tx_data_o == $past(tdm_slot_data[abrc_pkg::SLOT_EXT]))
    else $error("transmitter data wrong slot");
  a_rx_cfg_pulse: assert property (
    rx_chg |=> !rx_reset_n && rx_cnt_r == PULSE_LOAD)
    else $error("receiver reset pulse missing");
  a_rx_pulse_end: assert property (
    (rx_cnt_r == CNT_ONE && !rx_chg && rx_nxt[abrc_pkg::RX_RST]) |=> rx_reset_n)
    else $error("receiver reset not released");
  a_adc_fmt_pulse: assert property (
    adc_chg |=> !adc_reset_n && am_cnt_r == PULSE_LOAD)
    else $error("adc reset pulse missing");
  a_adc_busy_low: assert property (
    (am_cnt_r != CNT_ZERO) |-> !adc_reset_n)
    else $error("adc reset high during pulse");
  a_dac_exclusive: assert property (
    dsp_dac_ext_en_n != fpga_dac_buf_en_n)
    else $error("two dac data sources");
  a_aux_rx_route: assert property (
    by_r[abrc_pkg::BY_AUX] |-> !aux_oe_n ##1 aux_serial_input_o == $past(rx_sdout))
    else $error("aux input not from receiver");
  a_hdr_raw_route: assert property (
    (hd_r[abrc_pkg::HD_SEL_HI:abrc_pkg::HD_SEL_LO] == abrc_pkg::HD_SEL_RAW)
      |=> hdr_data_o == $past(converter_serial_output))
    else $error("header data not raw");
  a_div15_rate: assert property (
    (div_en[0] && !div_sel[0]) [*4] ##0 (int_clk_en && $past(int_clk_en))
      |=> !int_clk_en)
    else $error("divide by 1.5 pattern wrong");
  a_div20_rate: assert property (
    (div_en[1] && div_sel[1]) [*3] ##0 adc_clk_en |=> !adc_clk_en)
    else $error("divide by 2.0 pattern wrong");

  c_rx_pulse: cover property (rx_chg ##1 !rx_reset_n);
  c_adc_pulse: cover property (adc_chg ##1 !adc_reset_n);
  c_div15: cover property ((div_en[0] && !div_sel[0]) [*4]);
  c_bypass: cover property (!bypass_buf_en_n && codec_clk_oe_n);

endmodule

// ---- tb/abrc_far_side.sv ----
`timescale 1ns/10ps
// Peripheral side: sub-clocks and serial data from a pattern that shifts on every cycle
module abrc_far_side (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  output logic            dsp_bclk,
  output logic            dsp_lrck,
  output logic            tdm_bclk,
  output logic            tdm_lrck,
  output logic [3:0]      tdm_slot_data,
  output logic            converter_serial_output,
  output logic            rx_sdout
);
  logic [9:0] lfsr_r;
  logic [9:0] lfsr_nxt;

  // Maximal-length shift pattern so no line holds a stale value
  always_comb begin
    lfsr_nxt = {lfsr_r[8:0], lfsr_r[9] ^ lfsr_r[6]};
  end

  // Pattern register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lfsr_r <= 10'h2A5;
    end else begin
      lfsr_r <= lfsr_nxt;
    end
  end

  // Fan the pattern out to the peripheral lines
  assign {dsp_bclk, dsp_lrck, tdm_bclk, tdm_lrck, tdm_slot_data, converter_serial_output, rx_sdout} = lfsr_r;
endmodule

// ---- tb/tb_audio_board_routing_control.sv ----
`timescale 1ns/10ps
module tb_audio_board_routing_control;
  localparam int unsigned N = 8;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  paddr = 10'h000;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [3:0]  pstrb = 4'h0;
  logic        pready, pslverr, dsp_bclk, dsp_lrck, tdm_bclk, tdm_lrck, converter_serial_output, rx_sdout;
  logic [3:0]  tdm_slot_data;
  logic        codec_bclk_o, codec_lrck_o, codec_clk_oe_n, tx_data_o, tx_clock_ratio_select, tx_serial_format_select;
  logic        rx_reset_n, rx_master_mode, rx_clock_ratio_select, rx_serial_format_select, recovered_clock_drive_n;
  logic        bypass_buf_en_n, dsp_dac_ext_en_n, fpga_dac_buf_en_n, adc_aux_ext_en_n, aux_serial_input_o, aux_oe_n;
  logic        hdr_data_o, dsp_mclk_drive, adc_serial_format, adc_reset_n, int_clk_en, adc_clk_en;
  wire  [9:0]  fs = {dsp_bclk, dsp_lrck, tdm_bclk, tdm_lrck, tdm_slot_data, converter_serial_output, rx_sdout};
  logic [7:0]  r_idx [6] = '{abrc_pkg::IDX_CODEC_CLK, abrc_pkg::IDX_TX_CTRL, abrc_pkg::IDX_RX_CTRL,
                             abrc_pkg::IDX_BYPASS, abrc_pkg::IDX_HDR_CTRL, abrc_pkg::IDX_ADC_MISC};
  logic [7:0]  r_msk [6] = '{abrc_pkg::MASK_CODEC_CLK, abrc_pkg::MASK_TX_CTRL, abrc_pkg::MASK_RX_CTRL,
                             abrc_pkg::MASK_BYPASS, abrc_pkg::MASK_HDR_CTRL, abrc_pkg::MASK_ADC_MISC};
  logic [7:0]  r_rst [6] = '{8'h06, 8'h20, 8'h18, 8'hC0, 8'h00, 8'h01};
  int unsigned n_mismatch = 0, compares = 0, cyc = 0, n0, n1;
  integer      seed = 32'hefbf;
  logic [31:0] rd;
  logic [7:0]  d, k, pv;
  logic        er;

  abrc_routing_ctrl #(.RST_PULSE_CYCLES(N)) uut (.ref_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .dsp_bclk, .dsp_lrck, .tdm_bclk, .tdm_lrck, .tdm_slot_data,
    .converter_serial_output, .rx_sdout, .codec_bclk_o, .codec_lrck_o, .codec_clk_oe_n, .tx_data_o,
    .tx_clock_ratio_select, .tx_serial_format_select, .rx_reset_n, .rx_master_mode, .rx_clock_ratio_select,
    .rx_serial_format_select, .recovered_clock_drive_n, .bypass_buf_en_n, .dsp_dac_ext_en_n, .fpga_dac_buf_en_n,
    .adc_aux_ext_en_n, .aux_serial_input_o, .aux_oe_n, .hdr_data_o, .dsp_mclk_drive, .adc_serial_format,
    .adc_reset_n, .int_clk_en, .adc_clk_en);
  abrc_far_side far (.ref_clk, .rst, .dsp_bclk, .dsp_lrck, .tdm_bclk, .tdm_lrck, .tdm_slot_data,
    .converter_serial_output, .rx_sdout);

  // Clock at 250 MHz
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] st);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0000_00, wd};
    pstrb <= st;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Access phase ends at the rising edge that sees pready high
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic wr(input int r, input logic [7:0] v);
    apb(1'b1, r_idx[r], v, 4'hF);
  endtask

  // Length in cycles of the next low stretch of a reset line
  task automatic low_len(input logic s, output int unsigned n);
    int unsigned g = 0;
    n = 0;
    while ((s ? adc_reset_n : rx_reset_n) !== 1'b0 && g < 4) begin @(negedge ref_clk); g++; end
    while ((s ? adc_reset_n : rx_reset_n) === 1'b0 && n < 100) begin @(negedge ref_clk); n++; end
  endtask

  // Routed outputs against the inputs of one cycle before
  task automatic route(input logic [7:0] i);
    logic [9:0] p;
    repeat (3) @(negedge ref_clk);
    p = fs;
    repeat (8) begin
      @(negedge ref_clk);
      chk({codec_bclk_o, codec_lrck_o}, i[1] ? (i[0] ? p[7:6] : p[9:8]) : 2'b00);
      chk(tx_data_o, i[2] ? p[2 + i[1:0]] : 1'b0);
      chk(hdr_data_o, i[1:0] == 2'b00 ? (i[2] ? p[5] : p[1]) : p[1 + i[1:0]]);
      chk(aux_serial_input_o, i[2] & p[0]);
      p = fs;
    end
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    fork
      low_len(1'b0, n0);
      low_len(1'b1, n1);
    join
    chk(n0, N);
    chk(n1, N);
    for (int j = 0; j < 6; j++) begin
      apb(1'b0, r_idx[j], 8'h00, 4'h0);
      chk(rd, {24'h0000_00, r_rst[j]});
      chk(er, 1'b0);
    end
    apb(1'b1, r_idx[4], 8'h39, 4'h0);
    apb(1'b0, r_idx[4], 8'h00, 4'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h09, 8'h00, 4'h0);
    chk(rd, 32'h0000_0000);
    chk(er, 1'b1);
    for (int i = 0; i < 8; i++) begin
      k = 8'(i);
      d = 8'($random(seed));
      wr(0, {5'h00, k[1:0], ~k[0]});
      wr(1, {2'b00, k[2:0], d[1:0], 1'b0});
      wr(3, {k[0], k[1], 1'b0, k[2], 4'h0});
      wr(4, {2'b00, k[2:0], 2'b00, d[2]});
      chk({codec_clk_oe_n, bypass_buf_en_n}, {~k[0], k[0]});
      chk({tx_clock_ratio_select, tx_serial_format_select}, d[1:0]);
      chk({dsp_dac_ext_en_n, fpga_dac_buf_en_n}, {k[1], ~k[1]});
      chk({adc_aux_ext_en_n, aux_oe_n}, {k[2], ~k[2]});
      chk(dsp_mclk_drive, d[2]);
      route(k);
    end
    for (int j = 0; j < 6; j++) begin
      d = 8'($random(seed));
      wr(j, d);
      apb(1'b0, r_idx[j], 8'h00, 4'h0);
      chk(rd, {24'h0000_00, d & r_msk[j]});
    end
    wr(2, 8'h18);
    repeat (2 * N + 4) @(negedge ref_clk);
    pv = 8'h18;
    for (int j = 0; j < 5; j++) begin
      d = (j == 0) ? pv : (j == 1) ? pv ^ 8'h04 : 8'($random(seed));
      d = {3'b000, 1'b1, d[3:0]};
      wr(2, d);
      chk({rx_master_mode, rx_clock_ratio_select, rx_serial_format_select, recovered_clock_drive_n}, d[3:0]);
      if (d[3:1] != pv[3:1]) begin
        low_len(1'b0, n0);
        chk(n0, N);
      end else begin
        repeat (4) @(negedge ref_clk);
        chk(rx_reset_n, 1'b1);
      end
      pv = d;
    end
    wr(2, {4'h0, pv[3:0]});
    repeat (2 * N + 4) @(negedge ref_clk);
    chk(rx_reset_n, 1'b0);
    wr(5, 8'h01);
    repeat (2 * N + 4) @(negedge ref_clk);
    wr(5, 8'h03);
    chk(adc_serial_format, 1'b1);
    low_len(1'b1, n1);
    chk(n1, N);
    wr(5, 8'h02);
    repeat (2 * N + 4) @(negedge ref_clk);
    chk(adc_reset_n, 1'b0);
    for (int j = 0; j < 3; j++) begin
      wr(5, j == 0 ? 8'h02 : j == 1 ? 8'h2E : 8'h3A);
      n0 = 0;
      n1 = 0;
      repeat (6) begin
        @(negedge ref_clk);
        n0 += int'(int_clk_en === 1'b1);
        n1 += int'(adc_clk_en === 1'b1);
      end
      chk(n0, j == 0 ? 6 : j == 1 ? 4 : 3);
      chk(n1, j == 0 ? 6 : j == 1 ? 3 : 4);
    end
    // Reset in mid-run: defaults back, both reset pulses again
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk({int_clk_en, adc_clk_en, adc_serial_format}, 3'b110);
    fork
      low_len(1'b0, n0);
      low_len(1'b1, n1);
    join
    chk(n0, N);
    chk(n1, N);
    apb(1'b0, r_idx[5], 8'h00, 4'h0);
    chk(rd, {24'h0000_00, r_rst[5]});
    stop_test();
  end
endmodule
